// ### bench/cif_regs_checker.sv
// Assertion checker for the camera image feature register bank ports.
`timescale 1ns/10ps
module cif_regs_checker
  import cif_pkg::*;
(
  // Clock and reset.
  input wire logic           REF_CLK,
  input wire logic           RST,
  // Register port.
  input wire cif_bus_req_t   BUS_REQ,
  input wire logic [31:0]    BUS_RDATA,
  // Datapath and shading memory.
  input wire cif_pix_in_t    PIX_IN,
  input wire cif_pix_out_t   PIX_OUT,
  input wire logic [31:0]    SHADE_RDATA,
  input wire cif_shade_mem_t SHADE_MEM
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  // A read strobe aimed at one address.
  sequence s_rd(a);
    BUS_REQ.rd && BUS_REQ.addr == a;
  endsequence

  // Read data must be quiet when no read was taken, so stale words never leak.
  property p_rd_idle;
    !BUS_REQ.rd |=> BUS_RDATA == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_unmapped;
    s_rd(32'hf1000300) |=> BUS_RDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_info;
    s_rd(CIF_DEF_INFO_ADDR) |=> BUS_RDATA == {1'h1, 3'h0, CIF_THR_FLOOR, CIF_THR_CEILING,
                                               CIF_DEFECT_CAPACITY};
  endproperty
  a_info: assert property (p_info) else $error("defect info word wrong");
  property p_capacity;
    s_rd(CIF_DEFER_ADDR) |=> BUS_RDATA[31] && BUS_RDATA[15:8] == CIF_QUEUE_CAPACITY
                             && BUS_RDATA[23:16] == 8'h00;
  endproperty
  a_capacity: assert property (p_capacity) else $error("queue capacity wrong");
  property p_grab;
    $onehot(PIX_OUT.shade_grab) && PIX_OUT.shade_grab <= CIF_GRAB_MAX;
  endproperty
  a_grab: assert property (p_grab) else $error("grab count not a capped power of two");
  // A memory write may only follow a buffer write on the bus.
  property p_we_src;
    SHADE_MEM.we |-> $past(BUS_REQ.wr) && $past(BUS_REQ.addr) == CIF_SHARED_BUF_ADDR;
  endproperty
  a_we_src: assert property (p_we_src) else $error("memory write without buffer write");
  property p_step;
    SHADE_MEM.we |-> SHADE_MEM.rd_addr == SHADE_MEM.wr_addr + CIF_SHADE_STEP;
  endproperty
  a_step: assert property (p_step) else $error("byte offset did not advance");
  property p_max_rate;
    !PIX_IN.scalable_active [*3] |-> !PIX_OUT.max_rate;
  endproperty
  a_max_rate: assert property (p_max_rate) else $error("max rate outside scalable format");
endmodule : cif_regs_checker

bind cif_regs cif_regs_checker u_chk (.REF_CLK(REF_CLK), .RST(RST), .BUS_REQ(BUS_REQ),
  .BUS_RDATA(BUS_RDATA), .PIX_IN(PIX_IN), .PIX_OUT(PIX_OUT), .SHADE_RDATA(SHADE_RDATA),
  .SHADE_MEM(SHADE_MEM));

// ### bench/cif_regs_tb.sv
// Self-checking testbench for the camera image feature register bank.
`timescale 1ns/10ps
module cif_regs_tb;
  import cif_pkg::*;
  logic           REF_CLK;
  logic           RST;
  cif_bus_req_t   req;
  cif_pix_in_t    pix;
  logic [31:0]    rdata;
  logic [31:0]    shade_rd;
  cif_pix_out_t   pout;
  cif_shade_mem_t smem;
  int             num_errors;
  int             checked;
  int             tx_n;
  int             cycles;

  cif_regs dut (.REF_CLK(REF_CLK), .RST(RST), .BUS_REQ(req), .BUS_RDATA(rdata), .PIX_IN(pix),
    .PIX_OUT(pout), .SHADE_RDATA(shade_rd), .SHADE_MEM(smem));

  // Memory model returns its own address, so read data shows which offset was used.
  assign shade_rd = {8'h00, smem.rd_addr};

  initial
  begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end

  // Releases counted and hangs cut short at a ceiling well past the run length.
  always @(posedge REF_CLK)
  begin
    cycles++;
    if (pout.tx_release === 1'b1) tx_n++;
    if (cycles > 20000)
    begin
      num_errors++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // A gap cycle after each strobe keeps one assignment per signal per step.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge REF_CLK);
    req <= '0;
    @(posedge REF_CLK);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    req <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
    @(posedge REF_CLK);
    req <= '0;
    #1 chk(rdata & m, e);
    @(posedge REF_CLK);
  endtask : rd

  task automatic frame();
    pix.frame_active <= 1'h1;
    @(posedge REF_CLK);
    pix.frame_active <= 1'h0;
    @(posedge REF_CLK);
  endtask : frame

  task automatic t_info();
    rd(CIF_DEF_INFO_ADDR, 32'hffffffff, 32'h803fc400);
    rd(32'hf1000300, 32'hffffffff, 32'h0);
  endtask : t_info

  task automatic t_frames();
    wr(CIF_FRAME_INFO_ADDR, 32'h40000000);
    repeat (3) frame();
    rd(CIF_FRAME_COUNT_ADDR, 32'hffffffff, 32'h3);
    rd(CIF_FRAME_MIRROR_ADDR, 32'hffffffff, 32'h3);
    rd(CIF_FRAME_INFO_ADDR, 32'hffffffff, 32'h80000000);
    wr(CIF_FRAME_INFO_ADDR, 32'h40000000);
    frame();
    rd(CIF_FRAME_COUNT_ADDR, 32'hffffffff, 32'h1);
  endtask : t_frames

  task automatic t_defer();
    wr(CIF_DEFER_ADDR, 32'h02000000);
    repeat (2) frame();
    rd(CIF_DEFER_ADDR, 32'h0600ffff, 32'h02001002);
    chk(32'(tx_n), 32'h0);
    tx_n = 0;
    wr(CIF_DEFER_ADDR, 32'h06000002);
    repeat (6) @(posedge REF_CLK);
    chk(32'(tx_n), 32'h2);
    rd(CIF_DEFER_ADDR, 32'h0600ffff, 32'h02001000);
    pix.scalable_active <= 1'h1;
    wr(CIF_DEFER_ADDR, 32'h03000000);
    @(posedge REF_CLK);
    #1 chk({31'h0, pout.max_rate}, 32'h1);
    @(posedge REF_CLK);
    pix.scalable_active <= 1'h0;
    repeat (2) @(posedge REF_CLK);
    #1 chk({31'h0, pout.max_rate}, 32'h0);
    @(posedge REF_CLK);
  endtask : t_defer

  task automatic t_shade_buf();
    wr(CIF_SHADE_MEM_ADDR, 32'h04000010);
    wr(CIF_SHADE_MEM_ADDR, 32'h04000000);
    wr(CIF_SHARED_BUF_ADDR, 32'h11);
    wr(CIF_SHARED_BUF_ADDR, 32'h22);
    rd(CIF_SHADE_MEM_ADDR, 32'h06ffffff, 32'h04000008);
    wr(CIF_SHADE_MEM_ADDR, 32'h02000020);
    rd(CIF_SHARED_BUF_ADDR, 32'hffffffff, 32'h20);
    rd(CIF_SHARED_BUF_ADDR, 32'hffffffff, 32'h24);
    wr(CIF_SHADE_MEM_ADDR, 32'h00000010);
    wr(CIF_SHARED_BUF_ADDR, 32'h33);
    rd(CIF_SHADE_MEM_ADDR, 32'h06ffffff, 32'h00000010);
  endtask : t_shade_buf

  task automatic t_shade_build();
    logic [3:0] codes [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hf};
    wr(CIF_SHADE_CTRL_ADDR, 32'h07);
    rd(CIF_SHADE_CTRL_ADDR, 32'hff, 32'h04);
    wr(CIF_SHADE_CTRL_ADDR, 32'hc8);
    rd(CIF_SHADE_CTRL_ADDR, 32'hff, 32'h40);
    wr(CIF_SHADE_CTRL_ADDR, 32'h04000008);
    rd(CIF_SHADE_CTRL_ADDR, 32'h050000ff, 32'h05000008);
    pix.shade_done <= 1'h1;
    @(posedge REF_CLK);
    pix.shade_done <= 1'h0;
    repeat (2) @(posedge REF_CLK);
    rd(CIF_SHADE_CTRL_ADDR, 32'h050000ff, 32'h00000008);
    wr(CIF_SHADE_CTRL_ADDR, 32'h00000508);
    rd(CIF_SHADE_CTRL_ADDR, 32'h0000f000, 32'h0000f000);
    foreach (codes[i])
    begin
      pix.chan_code <= codes[i];
      pix.chan_valid <= 1'h1;
      @(posedge REF_CLK);
      pix.chan_valid <= 1'h0;
      @(posedge REF_CLK);
      rd(CIF_SHADE_CTRL_ADDR, 32'h0000f000, {16'h0, codes[i], 12'h0});
    end
  endtask : t_shade_build

  task automatic t_defect();
    wr(CIF_DEF_CTRL_ADDR, 32'h04000000);
    rd(CIF_DEF_CTRL_ADDR, 32'h05000000, 32'h05000000);
    repeat (257)
    begin
      pix.defect_entry_valid <= 1'h1;
      @(posedge REF_CLK);
      pix.defect_entry_valid <= 1'h0;
      @(posedge REF_CLK);
    end
    pix.defect_mean <= 7'h2a;
    pix.defect_done <= 1'h1;
    @(posedge REF_CLK);
    pix.defect_done <= 1'h0;
    repeat (2) @(posedge REF_CLK);
    rd(CIF_DEF_CTRL_ADDR, 32'h45003fff, 32'h40001501);
    rd(CIF_DEF_MEM_ADDR, 32'h0fffc000, 32'h00404000);
    wr(CIF_DEF_CTRL_ADDR, 32'h00800010);
    rd(CIF_DEF_CTRL_ADDR, 32'h00c0007f, 32'h00800010);
    pix.store_done <= 1'h1;
    @(posedge REF_CLK);
    pix.store_done <= 1'h0;
    repeat (2) @(posedge REF_CLK);
    rd(CIF_DEF_CTRL_ADDR, 32'h00c00000, 32'h0);
    wr(CIF_DEF_CTRL_ADDR, 32'h00200010);
    repeat (260) @(posedge REF_CLK);
    rd(CIF_DEF_MEM_ADDR, 32'h0fffc000, 32'h0);
    wr(CIF_DEF_MEM_ADDR, 32'h20000000);
    wr(CIF_SHARED_BUF_ADDR, 32'h000000a5);
    wr(CIF_DEF_MEM_ADDR, 32'h10000000);
    rd(CIF_SHARED_BUF_ADDR, 32'hffffffff, 32'h000000a5);
    rd(CIF_DEF_MEM_ADDR, 32'hb0003fff, 32'h90000004);
    wr(CIF_DEF_MEM_ADDR, 32'h00000000);
    pix.mode_zero <= 1'h1;
    wr(CIF_DEF_CTRL_ADDR, 32'h02000010);
    #1 chk({31'h0, pout.defect_corr_en}, 32'h1);
    @(posedge REF_CLK);
    pix.mode_zero <= 1'h0;
    @(posedge REF_CLK);
    #1 chk({31'h0, pout.defect_corr_en}, 32'h0);
    @(posedge REF_CLK);
  endtask : t_defect

  task automatic stop_test();
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  // Reset for six cycles, then the scenarios in turn.
  initial
  begin
    RST = 1'h1;
    req = '0;
    pix = '0;
    repeat (6) @(posedge REF_CLK);
    RST <= 1'h0;
    @(posedge REF_CLK);
    t_info();
    t_frames();
    t_defer();
    t_shade_buf();
    t_shade_build();
    t_defect();
    stop_test();
  end
endmodule : cif_regs_tb

// ### core/cif_pkg.sv
// Shared constants and carrier types for the camera image feature register bank.
package cif_pkg;

  // Register byte addresses.
  localparam logic [31:0] CIF_SHADE_CTRL_ADDR  = 32'hf1000250;
  localparam logic [31:0] CIF_SHADE_MEM_ADDR   = 32'hf1000254;
  localparam logic [31:0] CIF_DEFER_ADDR       = 32'hf1000260;
  localparam logic [31:0] CIF_FRAME_INFO_ADDR  = 32'hf1000270;
  localparam logic [31:0] CIF_FRAME_COUNT_ADDR = 32'hf1000274;
  localparam logic [31:0] CIF_DEF_CTRL_ADDR    = 32'hf1000298;
  localparam logic [31:0] CIF_DEF_MEM_ADDR     = 32'hf100029c;
  localparam logic [31:0] CIF_DEF_INFO_ADDR    = 32'hf10002a0;
  localparam logic [31:0] CIF_SHARED_BUF_ADDR  = 32'hf1000400;
  localparam logic [31:0] CIF_FRAME_MIRROR_ADDR = 32'hf1000610;

  // Field positions in little-endian terms; documented bit 0 is the word's top bit.
  localparam int CIF_PRESENCE_BIT = 31;
  localparam int CIF_FAIL_BIT     = 30;
  localparam int CIF_SHOW_BIT     = 27;
  localparam int CIF_BUILD_BIT    = 26;
  localparam int CIF_ONOFF_BIT    = 25;
  localparam int CIF_BUSY_BIT     = 24;
  localparam int CIF_SMEM_WR_BIT  = 26;
  localparam int CIF_SMEM_RD_BIT  = 25;
  localparam int CIF_SEND_BIT     = 26;
  localparam int CIF_HOLD_BIT     = 25;
  localparam int CIF_FAST_BIT     = 24;
  localparam int CIF_CNT_RESET_BIT = 30;
  localparam int CIF_SAVE_BIT     = 23;
  localparam int CIF_LOAD_BIT     = 22;
  localparam int CIF_ZERO_BIT     = 21;
  localparam int CIF_DMEM_WR_BIT  = 29;
  localparam int CIF_DMEM_RD_BIT  = 28;

  // Memory channel status codes.
  localparam logic [3:0] CIF_CHAN_OK        = 4'h0;
  localparam logic [3:0] CIF_CHAN_DETECT    = 4'h1;
  localparam logic [3:0] CIF_CHAN_SIZE      = 4'h2;
  localparam logic [3:0] CIF_CHAN_ERASE     = 4'h3;
  localparam logic [3:0] CIF_CHAN_WRITE     = 4'h4;
  localparam logic [3:0] CIF_CHAN_HEADER    = 4'h5;
  localparam logic [3:0] CIF_CHAN_RANGE     = 4'hf;

  // Capacities and limits.
  localparam logic [7:0]  CIF_QUEUE_CAPACITY  = 8'h10;
  localparam logic [7:0]  CIF_GRAB_MAX        = 8'h40;
  localparam logic [3:0]  CIF_SHADE_MAX_CHAN  = 4'h3;
  localparam logic [13:0] CIF_DEFECT_LIMIT    = 14'h0100;
  localparam logic [13:0] CIF_DEFECT_OVERFLOW = 14'h0101;
  localparam logic [13:0] CIF_DEFECT_CAPACITY = 14'h0400;
  localparam logic [6:0]  CIF_THR_FLOOR       = 7'h01;
  localparam logic [6:0]  CIF_THR_CEILING     = 7'h7f;
  localparam logic [6:0]  CIF_THR_RESET       = 7'h10;
  localparam logic [23:0] CIF_SHADE_STEP      = 24'h000004;
  localparam logic [13:0] CIF_DEFECT_STEP     = 14'h0004;

  // Register bus request.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cif_bus_req_t;

  // Events and data from the pixel datapath and storage controller.
  typedef struct packed {
    logic        frame_active;
    logic        scalable_active;
    logic        mode_zero;
    logic        shade_done;
    logic        shade_fail;
    logic        chan_valid;
    logic [3:0]  chan_code;
    logic        defect_entry_valid;
    logic [31:0] defect_entry_data;
    logic        defect_done;
    logic [6:0]  defect_mean;
    logic        store_done;
  } cif_pix_in_t;

  // Commands to the pixel datapath, transmitter and storage controller.
  typedef struct packed {
    logic       shade_start;
    logic [7:0] shade_grab;
    logic       shade_on;
    logic       shade_show;
    logic       defect_start;
    logic       defect_corr_en;
    logic [6:0] defect_threshold;
    logic       max_rate;
    logic       hold;
    logic       tx_release;
    logic       store_save;
    logic       store_load;
  } cif_pix_out_t;

  // Shading image memory port.
  typedef struct packed {
    logic [23:0] rd_addr;
    logic [23:0] wr_addr;
    logic [31:0] wdata;
    logic        we;
  } cif_shade_mem_t;

endpackage : cif_pkg

// ### core/cif_regs.sv
// Register bank for shading transfer, deferred transport, frame count and defect correction.
`timescale 1ns/10ps
module cif_regs
  import cif_pkg::*;
(
  // Clock and reset.
  input  wire logic           REF_CLK,
  input  wire logic           RST,
  // Register port.
  input  wire cif_bus_req_t   BUS_REQ,
  output logic [31:0]         BUS_RDATA,
  // Pixel datapath and storage.
  input  wire cif_pix_in_t    PIX_IN,
  output cif_pix_out_t        PIX_OUT,
  // Shading image memory.
  input  wire logic [31:0]    SHADE_RDATA,
  output cif_shade_mem_t      SHADE_MEM
);

  // The register state of the block, apart from the defect table and max_rate_q.
  typedef struct packed {
    logic [31:0]    rdata;
    cif_pix_out_t   pout;
    cif_shade_mem_t smem;
    logic           shade_fail;
    logic           shade_build;
    logic           shade_busy;
    logic [3:0]     chan_err;
    logic [3:0]     chan_sel;
    logic           shade_wr_en;
    logic           shade_rd_en;
    logic [23:0]    shade_offset;
    logic           send;
    logic [7:0]     send_left;
    logic [7:0]     queued;
    logic           frame_prev;
    logic [31:0]    frame_total;
    logic           def_fail;
    logic           def_build;
    logic           def_on;
    logic           def_busy;
    logic           def_save;
    logic           def_load;
    logic           def_zero;
    logic [8:0]     zero_idx;
    logic [6:0]     def_mean;
    logic           def_wr_en;
    logic           def_rd_en;
    logic [13:0]    def_count;
    logic [13:0]    def_offset;
  } cif_state_t;

  cif_state_t  st;
  cif_state_t  next_st;
  logic [31:0] defect_mem [0:255];
  logic        mem_we;
  logic [7:0]  mem_waddr;
  logic [31:0] mem_wdata;

  // Largest power of two not above the request, at least one, capped by buffers.
  function automatic logic [7:0] cif_grab_round(input logic [7:0] req);
    logic [7:0] res;
    res = 8'h01;
    for (int i = 0; i < 8; i++)
    begin
      if (req[i])
      begin
        res = 8'h01 << i;
      end
    end
    if (res > CIF_GRAB_MAX)
    begin
      res = CIF_GRAB_MAX;
    end
    return res;
  endfunction : cif_grab_round

  // Keeps the threshold inside the reported floor and ceiling.
  function automatic logic [6:0] cif_thr_clamp(input logic [6:0] thr);
    logic [6:0] res;
    res = thr;
    if (thr < CIF_THR_FLOOR)
    begin
      res = CIF_THR_FLOOR;
    end
    else if (thr > CIF_THR_CEILING)
    begin
      res = CIF_THR_CEILING;
    end
    return res;
  endfunction : cif_thr_clamp

  // Decoded single-cycle accesses.
  logic wr_shade_ctrl;
  logic wr_shade_mem;
  logic wr_defer;
  logic wr_frame_info;
  logic wr_def_ctrl;
  logic wr_def_mem;
  logic wr_buf;
  logic rd_buf;
  logic frame_rise;
  logic [7:0] released;
  logic [7:0] captured;

  always_comb
  begin
    wr_shade_ctrl = BUS_REQ.wr && (BUS_REQ.addr == CIF_SHADE_CTRL_ADDR);
    wr_shade_mem  = BUS_REQ.wr && (BUS_REQ.addr == CIF_SHADE_MEM_ADDR);
    wr_defer      = BUS_REQ.wr && (BUS_REQ.addr == CIF_DEFER_ADDR);
    wr_frame_info = BUS_REQ.wr && (BUS_REQ.addr == CIF_FRAME_INFO_ADDR);
    wr_def_ctrl   = BUS_REQ.wr && (BUS_REQ.addr == CIF_DEF_CTRL_ADDR);
    wr_def_mem    = BUS_REQ.wr && (BUS_REQ.addr == CIF_DEF_MEM_ADDR);
    wr_buf        = BUS_REQ.wr && (BUS_REQ.addr == CIF_SHARED_BUF_ADDR);
    rd_buf        = BUS_REQ.rd && (BUS_REQ.addr == CIF_SHARED_BUF_ADDR);
    frame_rise    = PIX_IN.frame_active && !st.frame_prev;
  end

  // Next-state logic; hardware events are applied after host writes so the hardware event wins, except the send self-clear, which a defer write overrides.
  always_comb
  begin
    next_st = st;
    mem_we = 1'b0;
    mem_waddr = 8'h00;
    mem_wdata = 32'h00000000;
    released = 8'h00;
    captured = 8'h00;
    next_st.pout.shade_start = 1'b0;
    next_st.pout.defect_start = 1'b0;
    next_st.pout.tx_release = 1'b0;
    next_st.pout.store_save = 1'b0;
    next_st.pout.store_load = 1'b0;
    next_st.smem.we = 1'b0;
    next_st.frame_prev = PIX_IN.frame_active;

    // Shading control writes; busy and fail are status only.
    if (wr_shade_ctrl)
    begin
      next_st.pout.shade_show = BUS_REQ.wdata[CIF_SHOW_BIT];
      next_st.pout.shade_on = BUS_REQ.wdata[CIF_ONOFF_BIT];
      next_st.chan_sel = BUS_REQ.wdata[11:8];
      next_st.pout.shade_grab = cif_grab_round(BUS_REQ.wdata[7:0]);
      if (BUS_REQ.wdata[11:8] > CIF_SHADE_MAX_CHAN)
      begin
        next_st.chan_err = CIF_CHAN_RANGE;
      end
      else
      begin
        next_st.chan_err = CIF_CHAN_OK;
      end
      if (BUS_REQ.wdata[CIF_BUILD_BIT] && !st.shade_busy)
      begin
        next_st.shade_build = 1'b1;
        next_st.shade_busy = 1'b1;
        next_st.shade_fail = 1'b0;
        next_st.pout.shade_start = 1'b1;
      end
    end
    // Storage controller reports a save or load outcome for the shading channel.
    if (PIX_IN.chan_valid)
    begin
      next_st.chan_err = PIX_IN.chan_code;
    end
    // Generation end drops both flags together.
    if (PIX_IN.shade_done && st.shade_busy)
    begin
      next_st.shade_build = 1'b0;
      next_st.shade_busy = 1'b0;
      next_st.shade_fail = PIX_IN.shade_fail;
    end

    // Shading memory access control; offset is loaded by the host.
    if (wr_shade_mem)
    begin
      next_st.shade_wr_en = BUS_REQ.wdata[CIF_SMEM_WR_BIT];
      next_st.shade_rd_en = BUS_REQ.wdata[CIF_SMEM_RD_BIT];
      next_st.shade_offset = BUS_REQ.wdata[23:0];
    end

    // Defect memory access control.
    if (wr_def_mem)
    begin
      next_st.def_wr_en = BUS_REQ.wdata[CIF_DMEM_WR_BIT];
      next_st.def_rd_en = BUS_REQ.wdata[CIF_DMEM_RD_BIT];
      next_st.def_offset = BUS_REQ.wdata[13:0];
    end

    // Shared buffer: defect memory takes it when enabled, else shading memory.
    if (wr_buf && st.def_wr_en)
    begin
      mem_we = 1'b1;
      mem_waddr = st.def_offset[9:2];
      mem_wdata = BUS_REQ.wdata;
      next_st.def_offset = st.def_offset + CIF_DEFECT_STEP;
    end
    else if (wr_buf && st.shade_wr_en)
    begin
      next_st.smem.we = 1'b1;
      next_st.smem.wr_addr = st.shade_offset;
      next_st.smem.wdata = BUS_REQ.wdata;
      next_st.shade_offset = st.shade_offset + CIF_SHADE_STEP;
    end
    if (rd_buf && st.def_rd_en)
    begin
      next_st.def_offset = st.def_offset + CIF_DEFECT_STEP;
    end
    else if (rd_buf && st.shade_rd_en)
    begin
      next_st.shade_offset = st.shade_offset + CIF_SHADE_STEP;
    end
    next_st.smem.rd_addr = next_st.shade_offset;

    // One held image leaves per cycle while a send is pending.
    if (st.send && st.send_left != 8'h00 && st.queued != 8'h00)
    begin
      released = 8'h01;
      next_st.pout.tx_release = 1'b1;
      next_st.send_left = st.send_left - 8'h01;
    end
    if (st.send && (st.send_left == 8'h00 || st.queued == 8'h00))
    begin
      next_st.send = 1'b0;
    end
    // Deferred transport control comes after the self-clear, so a new send request wins.
    if (wr_defer)
    begin
      next_st.pout.hold = BUS_REQ.wdata[CIF_HOLD_BIT];
      next_st.pout.max_rate = BUS_REQ.wdata[CIF_FAST_BIT];
      if (BUS_REQ.wdata[CIF_SEND_BIT])
      begin
        next_st.send = 1'b1;
        next_st.send_left = BUS_REQ.wdata[7:0];
      end
    end
    // Captured frames are held while hold is set; a full queue drops the frame.
    if (frame_rise && st.pout.hold && (st.queued - released) < CIF_QUEUE_CAPACITY)
    begin
      captured = 8'h01;
    end
    next_st.queued = st.queued - released + captured;

    // Frame counter: a counter reset and a new frame start in one cycle leave one frame.
    if (wr_frame_info && BUS_REQ.wdata[CIF_CNT_RESET_BIT])
    begin
      next_st.frame_total = frame_rise ? 32'h00000001 : 32'h00000000;
    end
    else if (frame_rise)
    begin
      next_st.frame_total = st.frame_total + 32'h00000001;
    end

    // Defect correction control; busy and fail are status only, while a write of the zero bit starts the table sweep.
    if (wr_def_ctrl)
    begin
      next_st.def_on = BUS_REQ.wdata[CIF_ONOFF_BIT];
      next_st.pout.defect_threshold = cif_thr_clamp(BUS_REQ.wdata[6:0]);
      if (BUS_REQ.wdata[CIF_BUILD_BIT] && !st.def_busy)
      begin
        next_st.def_build = 1'b1;
        next_st.def_busy = 1'b1;
        next_st.def_fail = 1'b0;
        next_st.def_count = 14'h0000;
        next_st.pout.defect_start = 1'b1;
      end
      if (BUS_REQ.wdata[CIF_SAVE_BIT] && !st.def_save && !st.def_load)
      begin
        next_st.def_save = 1'b1;
        next_st.pout.store_save = 1'b1;
      end
      else if (BUS_REQ.wdata[CIF_LOAD_BIT] && !st.def_save && !st.def_load)
      begin
        next_st.def_load = 1'b1;
        next_st.pout.store_load = 1'b1;
      end
      if (BUS_REQ.wdata[CIF_ZERO_BIT] && !st.def_zero)
      begin
        next_st.def_zero = 1'b1;
        next_st.zero_idx = 9'h000;
      end
    end
    if (PIX_IN.store_done)
    begin
      next_st.def_save = 1'b0;
      next_st.def_load = 1'b0;
    end
    // Entries beyond the limit are not stored; the count is pinned at CIF_DEFECT_OVERFLOW.
    if (st.def_busy && PIX_IN.defect_entry_valid)
    begin
      if (st.def_count < CIF_DEFECT_LIMIT)
      begin
        mem_we = 1'b1;
        mem_waddr = st.def_count[7:0];
        mem_wdata = PIX_IN.defect_entry_data;
        next_st.def_count = st.def_count + 14'h0001;
      end
      else
      begin
        next_st.def_count = CIF_DEFECT_OVERFLOW;
      end
    end
    if (st.def_busy && PIX_IN.defect_done)
    begin
      next_st.def_busy = 1'b0;
      next_st.def_build = 1'b0;
      next_st.def_mean = PIX_IN.defect_mean;
      next_st.def_fail = (next_st.def_count > CIF_DEFECT_LIMIT);
    end
    // Zeroing sweeps the whole table; it overrides other writers meanwhile.
    if (st.def_zero)
    begin
      mem_we = 1'b1;
      mem_waddr = st.zero_idx[7:0];
      mem_wdata = 32'h00000000;
      next_st.zero_idx = st.zero_idx + 9'h001;
      next_st.def_count = 14'h0000;
      if (st.zero_idx[8] || st.zero_idx == {1'b0, 8'hff})
      begin
        next_st.def_zero = 1'b0;
      end
    end
    // Correction runs only when the scalable format is in mode zero.
    next_st.pout.defect_corr_en = next_st.def_on && PIX_IN.mode_zero;
    next_st.pout.max_rate = wr_defer ? BUS_REQ.wdata[CIF_FAST_BIT] : st.pout.max_rate;

    // Read data, one cycle after the strobe; presence bits read one, reserved zero.
    next_st.rdata = 32'h00000000;
    if (BUS_REQ.rd)
    begin
      unique case (BUS_REQ.addr)
        CIF_SHADE_CTRL_ADDR:
        begin
          next_st.rdata[CIF_PRESENCE_BIT] = 1'b1;
          next_st.rdata[CIF_FAIL_BIT] = st.shade_fail;
          next_st.rdata[CIF_SHOW_BIT] = st.pout.shade_show;
          next_st.rdata[CIF_BUILD_BIT] = st.shade_build;
          next_st.rdata[CIF_ONOFF_BIT] = st.pout.shade_on;
          next_st.rdata[CIF_BUSY_BIT] = st.shade_busy;
          next_st.rdata[15:0] = {st.chan_err, st.chan_sel, st.pout.shade_grab};
        end
        CIF_SHADE_MEM_ADDR:
        begin
          next_st.rdata[CIF_PRESENCE_BIT] = 1'b1;
          next_st.rdata[CIF_SMEM_WR_BIT] = st.shade_wr_en;
          next_st.rdata[CIF_SMEM_RD_BIT] = st.shade_rd_en;
          next_st.rdata[23:0] = st.shade_offset;
        end
        CIF_DEFER_ADDR:
        begin
          next_st.rdata[CIF_PRESENCE_BIT] = 1'b1;
          next_st.rdata[CIF_SEND_BIT] = st.send;
          next_st.rdata[CIF_HOLD_BIT] = st.pout.hold;
          next_st.rdata[CIF_FAST_BIT] = st.pout.max_rate;
          next_st.rdata[15:0] = {CIF_QUEUE_CAPACITY, st.queued};
        end
        CIF_FRAME_INFO_ADDR:
        begin
          next_st.rdata[CIF_PRESENCE_BIT] = 1'b1;
        end
        CIF_FRAME_COUNT_ADDR, CIF_FRAME_MIRROR_ADDR:
        begin
          next_st.rdata = st.frame_total;
        end
        CIF_DEF_CTRL_ADDR:
        begin
          next_st.rdata[CIF_PRESENCE_BIT] = 1'b1;
          next_st.rdata[CIF_FAIL_BIT] = st.def_fail;
          next_st.rdata[CIF_BUILD_BIT] = st.def_build;
          next_st.rdata[CIF_ONOFF_BIT] = st.def_on;
          next_st.rdata[CIF_BUSY_BIT] = st.def_busy;
          next_st.rdata[CIF_SAVE_BIT] = st.def_save;
          next_st.rdata[CIF_LOAD_BIT] = st.def_load;
          next_st.rdata[CIF_ZERO_BIT] = st.def_zero;
          next_st.rdata[13:0] = {st.def_mean, st.pout.defect_threshold};
        end
        CIF_DEF_MEM_ADDR:
        begin
          next_st.rdata[CIF_PRESENCE_BIT] = 1'b1;
          next_st.rdata[CIF_DMEM_WR_BIT] = st.def_wr_en;
          next_st.rdata[CIF_DMEM_RD_BIT] = st.def_rd_en;
          next_st.rdata[27:0] = {st.def_count, st.def_offset};
        end
        CIF_DEF_INFO_ADDR:
        begin
          next_st.rdata[CIF_PRESENCE_BIT] = 1'b1;
          next_st.rdata[27:0] = {CIF_THR_FLOOR, CIF_THR_CEILING, CIF_DEFECT_CAPACITY};
        end
        CIF_SHARED_BUF_ADDR:
        begin
          if (st.def_rd_en)
          begin
            next_st.rdata = defect_mem[st.def_offset[9:2]];
          end
          else if (st.shade_rd_en)
          begin
            next_st.rdata = SHADE_RDATA;
          end
        end
        default:
        begin
          next_st.rdata = 32'h00000000;
        end
      endcase
    end
  end

  // Fast capture is forwarded only while the scalable format is active.
  logic max_rate_gate;
  assign max_rate_gate = st.pout.max_rate && PIX_IN.scalable_active;

  // State register; the defect table itself is not reset, zeroing clears it.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      st <= '0;
      st.pout.shade_grab <= 8'h01;
      st.pout.defect_threshold <= CIF_THR_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Defect table write port.
  always_ff @(posedge REF_CLK)
  begin
    if (mem_we)
    begin
      defect_mem[mem_waddr] <= mem_wdata;
    end
  end

  // Fast capture gate is registered so the output comes straight from a flop.
  logic max_rate_q;
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      max_rate_q <= 1'b0;
    end
    else
    begin
      max_rate_q <= max_rate_gate;
    end
  end

  // Output drive.
  always_comb
  begin
    BUS_RDATA = st.rdata;
    PIX_OUT = st.pout;
    PIX_OUT.max_rate = max_rate_q;
    SHADE_MEM = st.smem;
  end

endmodule : cif_regs
